// [common/tag_fifo_pkg.sv]
// constants and carriers for the tag fifo, interrupt and command unit
`default_nettype none
package tag_fifo_pkg;
	localparam int FIFO_DEPTH      = 32;
	localparam int WL_TX_LEVEL     = FIFO_DEPTH / 4;
	localparam int WL_RX_LEVEL     = (FIFO_DEPTH * 3) / 4;
	localparam int TXCNT_WIDTH     = 9;
	// serial frame mode bits
	localparam logic [1:0] MODE_REG_READ = 2'h1;
	localparam logic [1:0] MODE_FIFO     = 2'h2;
	localparam logic [1:0] MODE_COMMAND  = 2'h3;
	localparam logic [5:0] CODE_LOAD     = 6'h00;
	localparam logic [5:0] CODE_READ     = 6'h3f;
	// direct command codes (six low bits of the command byte)
	localparam logic [5:0] CMD_DEFAULT_A = 6'h02;
	localparam logic [5:0] CMD_DEFAULT_B = 6'h03;
	localparam logic [5:0] CMD_CLEAR_A   = 6'h04;
	localparam logic [5:0] CMD_CLEAR_B   = 6'h05;
	localparam logic [5:0] CMD_TRANSMIT  = 6'h08;
	localparam logic [5:0] CMD_HALT      = 6'h10;
	// readable register addresses
	localparam logic [5:0] ADDR_MAIN_IRQ = 6'h0a;
	localparam logic [5:0] ADDR_AUX_IRQ  = 6'h0b;
	localparam logic [5:0] ADDR_FIFO_ST1 = 6'h0c;
	localparam logic [5:0] ADDR_FIFO_ST2 = 6'h0d;
	// main interrupt bit positions
	localparam int MAIN_WATER      = 7;
	localparam int MAIN_RX_END     = 6;
	localparam int MAIN_TX_END     = 5;
	localparam int MAIN_FIFO_ERR   = 4;
	localparam int MAIN_EXT_LSB    = 1;
	localparam int MAIN_AUX_PTR    = 0;
	// auxiliary interrupt bit positions
	localparam int AUX_PARITY      = 0;
	localparam int AUX_TX_REJECT   = 1;
	localparam int AUX_EXT_LSB     = 2;
	// second fifo status register bit positions
	localparam int ST2_OVERFLOW    = 1;
	localparam int ST2_UNDERFLOW   = 0;
	// tag logic protocol modes
	localparam logic [1:0] PROT_LEVEL4   = 2'h0;
	localparam logic [1:0] PROT_LEVEL3   = 2'h1;
	localparam logic [7:0] IRQ_RESET     = 8'h00;

	typedef struct packed {
		logic [1:0] prot_mode;
		logic       rx_bitstream;
		logic       tx_bitstream;
	} mode_cfg_s;

	typedef struct packed {
		logic sclk;
		logic ss_n;
		logic mosi;
	} spi_in_s;

	typedef struct packed {
		logic bit_valid;
		logic bit_value;
		logic frame_end;
	} rx_air_s;
endpackage : tag_fifo_pkg
`default_nettype wire

// [core/tag_fifo_irq_command_unit.sv]
// host-facing fifo, interrupt registers, air bit mapping and direct commands
`default_nettype none
module tag_fifo_irq_command_unit
	import tag_fifo_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int TXW   = TXCNT_WIDTH
) (
	// clock and reset
	input  wire logic            ref_clk_i,
	input  wire logic            reset_i,
	// serial host pins
	input  wire spi_in_s         spi_i,
	output logic                 miso_o,
	output logic                 miso_oe_o,
	output logic                 irq_o,
	// configuration and field state
	input  wire mode_cfg_s       mode_i,
	input  wire logic            field_present_threshold_i,
	input  wire logic            level4_active_i,
	input  wire logic [TXW-1:0]  tx_byte_count_i,
	input  wire logic [7:0]      mask_main_i,
	input  wire logic [7:0]      mask_aux_i,
	input  wire logic [2:0]      ext_main_event_i,
	input  wire logic [5:0]      ext_aux_event_i,
	// receive air bits
	input  wire rx_air_s         rx_i,
	// transmit air bits
	input  wire logic            tx_bit_req_i,
	output logic                 tx_bit_o,
	output logic                 tx_last_o,
	output logic                 tx_active_o,
	// command pulses and status
	output logic                 set_default_o,
	output logic                 clear_o,
	output logic                 tx_start_o,
	output logic                 halt_tag_command_o,
	output logic [5:0]           fifo_count_o,
	output logic                 fifo_overflow_o,
	output logic                 fifo_underflow_o
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [CW-1:0] WL_TX_C = CW'(WL_TX_LEVEL);
	localparam logic [CW-1:0] WL_RX_C = CW'(WL_RX_LEVEL);

	typedef enum logic [2:0] {F_HEAD, F_LOAD, F_READ, F_REG, F_DONE} frame_e;

	typedef struct packed {
		logic [2:0]                 sclk_s;
		logic [2:0]                 ss_s;
		logic [2:0]                 mosi_s;
		logic                       sclk_f;
		logic                       ss_f;
		logic                       mosi_f;
		frame_e                     frame;
		logic [2:0]                 bit_cnt;
		logic [6:0]                 sh_in;
		logic [7:0]                 sh_out;
		logic                       miso;
		logic                       miso_oe;
		logic [DEPTH-1:0][7:0]      mem;
		logic [PW-1:0]              wr_ptr;
		logic [PW-1:0]              rd_ptr;
		logic [CW-1:0]              count;
		logic                       ovf;
		logic                       unf;
		logic                       wl_prev;
		logic [7:0]                 main_irq;
		logic [7:0]                 aux_irq;
		logic                       irq;
		logic                       rx_active;
		logic [3:0]                 rx_idx;
		logic [7:0]                 rx_byte;
		logic                       tx_active;
		logic [3:0]                 tx_idx;
		logic [7:0]                 tx_byte;
		logic [TXW-1:0]             tx_left;
		logic                       tx_bit;
		logic                       tx_last;
		logic                       set_default;
		logic                       clear;
		logic                       tx_start;
		logic                       halt;
	} state_s;

	localparam state_s RESET_STATE = '{ss_s: 3'h7, ss_f: 1'b1, frame: F_HEAD,
		main_irq: IRQ_RESET, aux_irq: IRQ_RESET, default: '0};

	state_s q;
	state_s d;

	logic       sclk_n;
	logic       ss_n_n;
	logic       mosi_n;
	logic       fall;
	logic       rise;
	logic [7:0] byte_in;
	logic       push;
	logic [7:0] push_data;
	logic       pop;
	logic [7:0] pop_data;
	logic       spi_pop;
	logic       tx_pop;
	logic       rx_push;
	logic [7:0] rx_nb;
	logic [7:0] cur_tx;
	logic [3:0] nbits;
	logic [7:0] ev_main;
	logic [7:0] ev_aux;
	logic       rd_main;
	logic       rd_aux;
	logic       do_default;
	logic       do_clear;
	logic       fifo_op;
	logic       wl_side;
	logic [CW-1:0] cnt_next;

	always_comb begin
		d          = q;
		ev_main    = '0;
		ev_aux     = '0;
		rd_main    = 1'b0;
		rd_aux     = 1'b0;
		do_default = 1'b0;
		do_clear   = 1'b0;
		push       = 1'b0;
		push_data  = '0;
		spi_pop    = 1'b0;
		tx_pop     = 1'b0;
		rx_push    = 1'b0;
		rx_nb      = '0;
		cur_tx     = '0;
		byte_in    = '0;
		d.set_default = 1'b0;
		d.clear       = 1'b0;
		d.tx_start    = 1'b0;
		d.halt        = 1'b0;
		pop_data   = (q.count == '0) ? 8'h00 : q.mem[q.rd_ptr];
		// pin synchronisers, change accepted when stages two and three agree
		d.sclk_s = {q.sclk_s[1:0], spi_i.sclk};
		d.ss_s   = {q.ss_s[1:0], spi_i.ss_n};
		d.mosi_s = {q.mosi_s[1:0], spi_i.mosi};
		sclk_n = (q.sclk_s[1] == q.sclk_s[2]) ? q.sclk_s[2] : q.sclk_f;
		ss_n_n = (q.ss_s[1] == q.ss_s[2]) ? q.ss_s[2] : q.ss_f;
		mosi_n = (q.mosi_s[1] == q.mosi_s[2]) ? q.mosi_s[2] : q.mosi_f;
		d.sclk_f = sclk_n;
		d.ss_f   = ss_n_n;
		d.mosi_f = mosi_n;
		fall = q.sclk_f & ~sclk_n & ~ss_n_n;
		rise = ~q.sclk_f & sclk_n & ~ss_n_n;
		if (ss_n_n) begin
			d.frame   = F_HEAD;
			d.bit_cnt = '0;
			d.miso_oe = 1'b0;
			d.miso    = 1'b0;
		end
		// serial frame decode, input sampled on the clock fall
		if (fall) begin
			byte_in   = {q.sh_in, mosi_n};
			d.sh_in   = byte_in[6:0];
			d.bit_cnt = q.bit_cnt + 3'h1;
			if (q.bit_cnt == 3'h7) begin
				d.sh_out = 8'h00;
				unique case (q.frame)
					F_HEAD: begin
						if (byte_in[7:6] == MODE_FIFO && byte_in[5:0] == CODE_LOAD) begin
							d.frame = F_LOAD;
						end else if (byte_in[7:6] == MODE_FIFO &&
							byte_in[5:0] == CODE_READ) begin
							d.frame  = F_READ;
							spi_pop  = 1'b1;
							d.sh_out = pop_data;
						end else if (byte_in[7:6] == MODE_REG_READ) begin
							d.frame = F_REG;
							unique case (byte_in[5:0])
								ADDR_MAIN_IRQ: begin
									d.sh_out = q.main_irq;
									rd_main  = 1'b1;
								end
								ADDR_AUX_IRQ: begin
									d.sh_out = q.aux_irq;
									rd_aux   = 1'b1;
								end
								ADDR_FIFO_ST1: d.sh_out = 8'(q.count);
								ADDR_FIFO_ST2: d.sh_out = {6'h00, q.ovf, q.unf};
								default: d.sh_out = 8'h00;
							endcase
						end else if (byte_in[7:6] == MODE_COMMAND) begin
							d.frame = F_DONE;
							unique case (byte_in[5:0])
								CMD_DEFAULT_A, CMD_DEFAULT_B: do_default = 1'b1;
								CMD_CLEAR_A, CMD_CLEAR_B: do_clear = 1'b1;
								CMD_TRANSMIT: begin
									if (field_present_threshold_i && (level4_active_i ||
										mode_i.prot_mode[1])) begin
										d.tx_start  = 1'b1;
										d.tx_active = 1'b1;
										d.tx_idx    = '0;
										d.tx_left   = tx_byte_count_i;
									end else begin
										ev_aux[AUX_TX_REJECT] = 1'b1;
									end
								end
								CMD_HALT: begin
									d.halt = field_present_threshold_i &&
										!mode_i.prot_mode[1];
								end
								default: d.frame = F_DONE;
							endcase
						end else begin
							d.frame = F_DONE;
						end
					end
					F_LOAD: begin
						push      = 1'b1;
						push_data = byte_in;
					end
					F_READ: begin
						spi_pop  = 1'b1;
						d.sh_out = pop_data;
					end
					F_REG, F_DONE: d.frame = q.frame;
				endcase
			end
		end
		// read data leaves msb first on the clock rise
		if (rise && (q.frame == F_READ || q.frame == F_REG)) begin
			d.miso    = q.sh_out[7];
			d.sh_out  = {q.sh_out[6:0], 1'b0};
			d.miso_oe = 1'b1;
		end
		// receive bit assembly
		if (rx_i.bit_valid) begin
			d.rx_active = 1'b1;
			rx_nb = (q.rx_idx == '0) ? 8'h00 : q.rx_byte;
			if (mode_i.rx_bitstream) begin
				rx_nb[3'(7 - q.rx_idx)] = rx_i.bit_value;
				d.rx_idx = (q.rx_idx == 4'h7) ? 4'h0 : q.rx_idx + 4'h1;
				rx_push  = (q.rx_idx == 4'h7);
			end else if (q.rx_idx == 4'h8) begin
				d.rx_idx = '0;
				rx_push  = 1'b1;
				ev_aux[AUX_PARITY] = ~(^{q.rx_byte, rx_i.bit_value});
				rx_nb = q.rx_byte;
			end else begin
				rx_nb[q.rx_idx[2:0]] = rx_i.bit_value;
				d.rx_idx = q.rx_idx + 4'h1;
			end
			d.rx_byte = rx_nb;
		end
		if (rx_i.frame_end) begin
			d.rx_active = 1'b0;
			d.rx_idx    = '0;
			ev_main[MAIN_RX_END] = 1'b1;
			if (mode_i.rx_bitstream && q.rx_idx != '0 && !rx_i.bit_valid) begin
				rx_push = 1'b1;
				rx_nb   = q.rx_byte;
			end
		end
		if (rx_push) begin
			push      = 1'b1;
			push_data = rx_nb;
		end
		// transmit bit source
		nbits  = mode_i.tx_bitstream ? 4'h8 : 4'h9;
		cur_tx = (q.tx_idx == '0) ? pop_data : q.tx_byte;
		if (tx_bit_req_i && q.tx_active) begin
			tx_pop    = (q.tx_idx == '0);
			d.tx_byte = cur_tx;
			if (mode_i.tx_bitstream) begin
				d.tx_bit = cur_tx[3'(7 - q.tx_idx)];
			end else if (q.tx_idx == 4'h8) begin
				d.tx_bit = ~(^cur_tx);
			end else begin
				d.tx_bit = cur_tx[q.tx_idx[2:0]];
			end
			d.tx_last = 1'b0;
			d.tx_idx  = q.tx_idx + 4'h1;
			if (q.tx_idx == nbits - 4'h1) begin
				d.tx_idx  = '0;
				d.tx_left = q.tx_left - TXW'(1);
				if (q.tx_left <= TXW'(1)) begin
					d.tx_last = 1'b1;
					d.tx_active = 1'b0;
					ev_main[MAIN_TX_END] = 1'b1;
				end
			end
		end
		// fifo storage, one push and one pop per cycle; transmit and host read share the pop
		pop = tx_pop | spi_pop;
		cnt_next = q.count;
		if (push) begin
			if (q.count == DEPTH_C && !pop) begin
				d.ovf = 1'b1;
				ev_main[MAIN_FIFO_ERR] = 1'b1;
			end else begin
				d.mem[q.wr_ptr] = push_data;
				d.wr_ptr = q.wr_ptr + PW'(1);
				cnt_next = cnt_next + CW'(1);
			end
		end
		if (pop) begin
			if (q.count == '0) begin
				d.unf = 1'b1;
				ev_main[MAIN_FIFO_ERR] = 1'b1;
			end else begin
				d.rd_ptr = q.rd_ptr + PW'(1);
				cnt_next = cnt_next - CW'(1);
			end
		end
		d.count = cnt_next;
		// water level, frozen while the host streams the fifo
		fifo_op = ~ss_n_n & (q.frame == F_LOAD || q.frame == F_READ);
		wl_side = (q.tx_active && cnt_next < WL_TX_C) ||
			(q.rx_active && cnt_next >= WL_RX_C);
		if (!fifo_op) begin
			ev_main[MAIN_WATER] = wl_side & ~q.wl_prev;
			d.wl_prev = wl_side;
		end
		ev_main[MAIN_EXT_LSB +: 3] = ext_main_event_i;
		ev_aux[7:AUX_EXT_LSB]     = ext_aux_event_i;
		ev_aux = ev_aux & ~mask_aux_i;
		ev_main[MAIN_AUX_PTR] = |ev_aux;
		// clear on read, main keeps its aux pointer bit until aux is read; a same-cycle event still sets its bit
		if (rd_main) begin
			d.main_irq = q.main_irq & 8'h01;
		end
		if (rd_aux) begin
			d.aux_irq = 8'h00;
			d.main_irq[MAIN_AUX_PTR] = 1'b0;
		end
		d.main_irq = d.main_irq | ev_main;
		d.aux_irq  = d.aux_irq | ev_aux;
		if (do_clear) begin
			d.clear     = 1'b1;
			d.wr_ptr    = '0;
			d.rd_ptr    = '0;
			d.count     = '0;
			d.ovf       = 1'b0;
			d.unf       = 1'b0;
			d.wl_prev   = 1'b0;
			d.tx_active = 1'b0;
			d.tx_idx    = '0;
			d.rx_active = 1'b0;
			d.rx_idx    = '0;
		end
		if (do_default) begin
			d             = RESET_STATE;
			d.sclk_s      = {q.sclk_s[1:0], spi_i.sclk};
			d.ss_s        = {q.ss_s[1:0], spi_i.ss_n};
			d.mosi_s      = {q.mosi_s[1:0], spi_i.mosi};
			d.sclk_f      = sclk_n;
			d.ss_f        = ss_n_n;
			d.mosi_f      = mosi_n;
			d.frame       = F_DONE;
			d.bit_cnt     = q.bit_cnt + 3'h1;
			d.set_default = 1'b1;
		end
		d.irq = |(d.main_irq & ~mask_main_i);
	end

	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= RESET_STATE;
		end else begin
			q <= d;
		end
	end

	assign miso_o             = q.miso;
	assign miso_oe_o          = q.miso_oe;
	assign irq_o              = q.irq;
	assign tx_bit_o           = q.tx_bit;
	assign tx_last_o          = q.tx_last;
	assign tx_active_o        = q.tx_active;
	assign set_default_o      = q.set_default;
	assign clear_o            = q.clear;
	assign tx_start_o         = q.tx_start;
	assign halt_tag_command_o = q.halt;
	assign fifo_count_o       = 6'(q.count);
	assign fifo_overflow_o    = q.ovf;
	assign fifo_underflow_o   = q.unf;
endmodule : tag_fifo_irq_command_unit
`default_nettype wire

// [verification/tag_fifo_props.sv]
// concurrent checks on the tag fifo, interrupt and command unit ports
`default_nettype none
module tag_fifo_props
	import tag_fifo_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input wire logic       ref_clk_i,
	input wire logic       reset_i,
	// pins and configuration
	input wire spi_in_s    spi_i,
	input wire mode_cfg_s  mode_i,
	input wire logic       field_present_threshold_i,
	input wire logic [7:0] mask_main_i,
	// observed outputs
	input wire logic       miso_oe_o,
	input wire logic       irq_o,
	input wire logic       set_default_o,
	input wire logic       clear_o,
	input wire logic       tx_start_o,
	input wire logic       halt_tag_command_o,
	input wire logic [5:0] fifo_count_o,
	input wire logic       fifo_overflow_o,
	input wire logic       fifo_underflow_o
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	halt_gate_a: assert property (
		halt_tag_command_o |-> field_present_threshold_i && !mode_i.prot_mode[1])
		else $error("halt outside field or protocol mode");
	tx_gate_a: assert property (
		tx_start_o |-> field_present_threshold_i)
		else $error("transmit started without field");
	clear_pulse_a: assert property (
		clear_o |=> !clear_o)
		else $error("clear pulse longer than one cycle");
	clear_effect_a: assert property (
		clear_o |-> ##[0:2] (fifo_count_o == 6'h00 && !fifo_overflow_o && !fifo_underflow_o))
		else $error("clear left count or flags");
	count_bound_a: assert property (
		fifo_count_o <= DEPTH)
		else $error("fifo count above depth");
	overflow_full_a: assert property (
		$rose(fifo_overflow_o) |-> fifo_count_o == DEPTH)
		else $error("overflow flagged while not full");
	underflow_empty_a: assert property (
		$rose(fifo_underflow_o) |-> fifo_count_o == 6'h00)
		else $error("underflow flagged while not empty");
	oe_release_a: assert property (
		$rose(spi_i.ss_n) |-> ##[1:6] !miso_oe_o)
		else $error("miso still driven after deselect");
	irq_mask_a: assert property (
		(mask_main_i == 8'hff) [*2] |-> !irq_o)
		else $error("interrupt pin high with all sources masked");
	default_state_a: assert property (
		set_default_o |-> ##[1:3] (!irq_o && fifo_count_o == 6'h00))
		else $error("set default left state behind");
endmodule // tag_fifo_props

bind tag_fifo_irq_command_unit tag_fifo_props #(.DEPTH(DEPTH)) props (
	.ref_clk_i,
	.reset_i,
	.spi_i,
	.mode_i,
	.field_present_threshold_i,
	.mask_main_i,
	.miso_oe_o,
	.irq_o,
	.set_default_o,
	.clear_o,
	.tx_start_o,
	.halt_tag_command_o,
	.fifo_count_o,
	.fifo_overflow_o,
	.fifo_underflow_o
);
`default_nettype wire

// [verification/spi_host_model.sv]
// serial master model standing in for the host controller
`default_nettype none
module spi_host_model
	import tag_fifo_pkg::*;
(
	// serial pins
	output var spi_in_s spi_o,
	input  wire logic   miso_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// 125 ns link period, well above the air rate
	localparam real HALF = 62.5;

	initial spi_o = '{sclk: 1'b0, ss_n: 1'b1, mosi: 1'b0};

	// frame starts with mode and code byte
	task automatic frame_open();
		spi_o.ss_n = 1'b0;
	endtask

	// mosi moves mid low phase, miso taken at the fall
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			#(HALF / 2) spi_o.mosi = tx[i];
			#(HALF / 2) spi_o.sclk = 1'b1;
			#(HALF) rx[i] = miso_i;
			spi_o.sclk = 1'b0;
		end
	endtask

	// deselect right after the last byte, mosi no longer valid
	task automatic frame_close();
		#(HALF) spi_o.ss_n = 1'b1;
		spi_o.mosi = ~spi_o.mosi;
		#(4 * HALF);
	endtask
endmodule // spi_host_model
`default_nettype wire

// [verification/tb_tag_fifo_irq_command_unit.sv]
// self-checking bench for the tag fifo, interrupt and command unit
`default_nettype none
module tb_tag_fifo_irq_command_unit import tag_fifo_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic       ref_clk_i                 = 1'b0;
	logic       reset_i                   = 1'b1;
	spi_in_s    spi_i;
	mode_cfg_s  mode_i                    = '0;
	logic       field_present_threshold_i = 1'b0;
	logic       level4_active_i           = 1'b0;
	logic [8:0] tx_byte_count_i           = '0;
	logic [7:0] mask_main_i               = '0;
	logic [2:0] ext_main_event_i          = '0;
	logic       seen_clr                  = 1'b1;
	rx_air_s    rx_i                      = '0;
	logic       tx_bit_req_i              = 1'b0;
	logic       miso_o, miso_oe_o, irq_o, tx_bit_o, tx_last_o, tx_active_o;
	logic       set_default_o, clear_o, tx_start_o, halt_tag_command_o;
	logic       fifo_overflow_o, fifo_underflow_o;
	logic [5:0] fifo_count_o;
	logic [3:0] seen;
	logic [7:0] v;
	logic [7:0] fill[$];
	int         err_count                 = 0;
	int         checked                   = 0;

	tag_fifo_irq_command_unit DUT (
		.ref_clk_i, .reset_i, .spi_i, .miso_o, .miso_oe_o, .irq_o, .mode_i,
		.field_present_threshold_i, .level4_active_i, .tx_byte_count_i, .mask_main_i,
		.mask_aux_i(8'h00), .ext_main_event_i, .ext_aux_event_i(6'h00), .rx_i,
		.tx_bit_req_i, .tx_bit_o, .tx_last_o, .tx_active_o, .set_default_o, .clear_o,
		.tx_start_o, .halt_tag_command_o, .fifo_count_o, .fifo_overflow_o, .fifo_underflow_o
	);
	spi_host_model host (.spi_o(spi_i), .miso_i(miso_o));

	always #5 ref_clk_i = ~ref_clk_i;
	// sticky record of command pulses
	always @(posedge ref_clk_i) begin
		seen <= seen_clr ? 4'h0 :
			(seen | {set_default_o, clear_o, tx_start_o, halt_tag_command_o});
	end

	task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic cmd(input logic [5:0] code);
		seen_clr = 1'b1;
		settle(1);
		seen_clr = 1'b0;
		host.frame_open();
		host.xbyte({MODE_COMMAND, code}, v);
		host.frame_close();
		settle(8);
	endtask
	task automatic load(input logic [7:0] q[$]);
		host.frame_open();
		host.xbyte({MODE_FIFO, CODE_LOAD}, v);
		foreach (q[i]) host.xbyte(q[i], v);
		host.frame_close();
		settle(8);
	endtask
	task automatic rdreg(input logic [5:0] a, input logic [7:0] exp, input string what);
		host.frame_open();
		host.xbyte({MODE_REG_READ, a}, v);
		host.xbyte(8'h00, v);
		host.frame_close();
		settle(8);
		check(what, v, exp);
	endtask
	task automatic rdfifo(input logic [7:0] q[$], input string what);
		host.frame_open();
		host.xbyte({MODE_FIFO, CODE_READ}, v);
		foreach (q[i]) begin
			host.xbyte(8'h00, v);
			check(what, v, q[i]);
		end
		host.frame_close();
		settle(8);
	endtask
	task automatic rxbits(input logic [8:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk_i) #1 rx_i = '{bit_valid: 1'b1, bit_value: b[i], frame_end: 1'b0};
			@(posedge ref_clk_i) #1 rx_i = '0;
		end
		@(posedge ref_clk_i) #1 rx_i.frame_end = 1'b1;
		@(posedge ref_clk_i) #1 rx_i.frame_end = 1'b0;
		settle(4);
	endtask
	task automatic txbits(input logic [17:0] exp, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk_i) #1 tx_bit_req_i = 1'b1;
			@(posedge ref_clk_i) #1 tx_bit_req_i = 1'b0;
			check("tx bit", {6'h00, tx_last_o, tx_bit_o}, {6'h00, i == n - 1, exp[i]});
		end
	endtask

	initial begin
		settle(10);
		reset_i = 1'b0;
		settle(2);
		check("state after reset", {irq_o, 1'b0, fifo_count_o}, 8'h00);
		load('{8'h11, 8'h22, 8'h33});
		rdreg(ADDR_FIFO_ST1, 8'h03, "status one");
		rdfifo('{8'h11, 8'h22, 8'h33}, "fifo data");
		rdreg(ADDR_FIFO_ST2, 8'h01, "status two");
		check("irq on fifo error", {7'h00, irq_o}, 8'h01);
		rdreg(ADDR_MAIN_IRQ, 8'h10, "main fifo error");
		check("irq released", {7'h00, irq_o}, 8'h00);
		cmd(CMD_CLEAR_A);
		check("clear", {seen, 2'b00, fifo_overflow_o, fifo_underflow_o}, 8'h40);
		for (int i = 0; i < 33; i++) fill.push_back(8'(i));
		load(fill);
		check("overflow", {fifo_overflow_o, 1'b0, fifo_count_o}, 8'hA0);
		rdreg(ADDR_MAIN_IRQ, 8'h10, "main overflow");
		cmd(CMD_CLEAR_B);
		check("clear b", {seen, 1'b0, fifo_overflow_o, fifo_count_o[5:4]}, 8'h40);
		cmd(CMD_TRANSMIT);
		check("tx refused", {seen, 3'b000, irq_o}, 8'h01);
		mask_main_i = 8'hff;
		settle(3);
		check("irq masked", {7'h00, irq_o}, 8'h00);
		mask_main_i = 8'h00;
		settle(3);
		rdreg(ADDR_MAIN_IRQ, 8'h01, "pointer kept");
		rdreg(ADDR_MAIN_IRQ, 8'h01, "pointer still");
		rdreg(ADDR_AUX_IRQ, 8'h02, "aux refused");
		rdreg(ADDR_MAIN_IRQ, 8'h00, "pointer cleared");
		check("irq idle", {7'h00, irq_o}, 8'h00);
		@(posedge ref_clk_i) #1 ext_main_event_i = 3'h5;
		@(posedge ref_clk_i) #1 ext_main_event_i = 3'h0;
		settle(2);
		rdreg(ADDR_MAIN_IRQ, 8'h0A, "external sources");
		field_present_threshold_i = 1'b1;
		level4_active_i = 1'b1;
		tx_byte_count_i = 9'h002;
		cmd(CMD_CLEAR_A);
		load('{8'hA5, 8'h01});
		cmd(CMD_TRANSMIT);
		check("tx start", {seen, 3'b000, tx_active_o}, 8'h21);
		txbits({~^8'h01, 8'h01, ~^8'hA5, 8'hA5}, 18);
		settle(4);
		check("tx ended", {7'h00, tx_active_o}, 8'h00);
		rdreg(ADDR_MAIN_IRQ, 8'hA0, "water and tx end");
		mode_i.tx_bitstream = 1'b1;
		tx_byte_count_i = 9'h001;
		cmd(CMD_CLEAR_A);
		load('{8'hC1});
		cmd(CMD_TRANSMIT);
		// bit-stream sends d7 first: c1 goes out as 1,1,0,0,0,0,0,1
		txbits(18'h0_0083, 8);
		level4_active_i = 1'b0;
		cmd(CMD_TRANSMIT);
		check("tx level gate", {seen, 3'b000, tx_active_o}, 8'h00);
		for (int m = 0; m < 5; m++) begin
			mode_i.prot_mode = 2'(m);
			field_present_threshold_i = (m != 4);
			cmd(CMD_HALT);
			check("halt", {seen, 4'h0}, (m < 2) ? 8'h10 : 8'h00);
		end
		mode_i = '0;
		cmd(CMD_CLEAR_A);
		rxbits({~^8'h3C, 8'h3C}, 9);
		rdfifo('{8'h3C}, "rx normal byte");
		cmd(CMD_CLEAR_A);
		mode_i.rx_bitstream = 1'b1;
		rxbits(9'h005, 3);
		rdfifo('{8'hA0}, "rx bitstream byte");
		for (int k = 0; k < 2; k++) begin
			cmd(k ? CMD_DEFAULT_B : CMD_DEFAULT_A);
			check("set default", {seen, 2'b00, fifo_count_o[1:0]}, 8'h80);
		end
		mode_i = '0;
		for (int i = 0; i < 24; i++) rxbits({~^8'(i), 8'(i)}, 9);
		rdreg(ADDR_FIFO_ST1, 8'h18, "rx count");
		rdreg(ADDR_MAIN_IRQ, 8'hC0, "rx water");
		print_verdict();
	end
endmodule // tb_tag_fifo_irq_command_unit
`default_nettype wire
